//--- verilog/sadc_host.sv
// host end: gated conversion clock, start strobe, two-byte or word reads into a fifo
`timescale 1ns/10ps
module sadc_host
  import sadc_pkg::*;
#(
  parameter int DATA_W = SADC_DATA_W,
  parameter int FIFO_DEPTH = 8,
  parameter bit BYTE_MODE = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  sadc_if.host pins,
  input wire logic start_req,
  output logic start_ack,
  output logic conv_active,
  output logic res_valid,
  input wire logic res_ready,
  output logic [DATA_W-1:0] res_data
);
  typedef enum logic [2:0] {SADC_H_IDLE, SADC_H_STRB, SADC_H_WAIT, SADC_H_RDLO, SADC_H_RDHI,
    SADC_H_PUSH} sadc_hstate_t;
  sadc_hstate_t state, next_state;
  logic [3:0] tcnt, next_tcnt;
  logic [1:0] div, next_div;
  logic ck, next_ck, strobe_n, next_strobe_n, rd_n, next_rd_n, bsel, next_bsel;
  logic [DATA_W-1:0] word, next_word;
  logic [2:0] busy_sync;
  logic seen_busy, next_seen_busy;
  logic fifo_ready;
  logic busy_now;
  logic ck_run;
  // busy is foreign: two settled stages must agree before acting
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_sync <= 3'h0;
    end else begin
      busy_sync <= {busy_sync[1:0], pins.busy};
    end
  end
  assign busy_now = busy_sync[1] && busy_sync[2];
  assign ck_run = (state == SADC_H_WAIT);
  always_comb begin
    next_state = state;
    next_tcnt = tcnt;
    next_div = div;
    next_ck = ck;
    next_strobe_n = strobe_n;
    next_rd_n = rd_n;
    next_bsel = bsel;
    next_word = word;
    next_seen_busy = seen_busy;
    // clock divided down; slow enough for the port's three-stage sampler
    if (ck_run) begin
      next_div = div + 2'h1;
      if (div == 2'(SADC_CONV_DIV)) begin
        next_div = 2'h0;
        next_ck = !ck;
      end
    end else begin
      next_div = 2'h0;
      next_ck = 1'b0;
    end
    unique case (state)
      SADC_H_IDLE: begin
        if (start_req && fifo_ready) begin
          next_strobe_n = 1'b0;
          next_tcnt = 4'(SADC_START_LOW_CYC + SADC_GUARD_POST_CYC + 2);
          next_state = SADC_H_STRB;
        end
      end
      SADC_H_STRB: begin
        // strobe held well past minimum so the port's sampler sees it
        next_tcnt = tcnt - 4'h1;
        if (tcnt == 4'h0) begin
          next_strobe_n = 1'b1;
          next_seen_busy = 1'b0;
          next_state = SADC_H_WAIT;
        end
      end
      SADC_H_WAIT: begin
        if (busy_now) begin
          next_seen_busy = 1'b1;
        end else if (seen_busy && !busy_sync[1] && !busy_sync[2]) begin
          next_rd_n = 1'b0;
          next_bsel = 1'b0;
          next_tcnt = 4'(SADC_RD_LOW_CYC + 1);
          next_state = SADC_H_RDLO;
        end
      end
      SADC_H_RDLO: begin
        next_tcnt = tcnt - 4'h1;
        if (tcnt == 4'h0) begin
          if (BYTE_MODE) begin
            next_word[SADC_BYTE_W-1:0] = pins.result_bus[SADC_BYTE_W-1:0];
            next_bsel = 1'b1;
            next_tcnt = 4'(SADC_RD_LOW_CYC + 1);
            next_state = SADC_H_RDHI;
          end else begin
            next_word = pins.result_bus;
            next_rd_n = 1'b1;
            next_tcnt = 4'(SADC_GUARD_PRE_CYC);
            next_state = SADC_H_PUSH;
          end
        end
      end
      SADC_H_RDHI: begin
        next_tcnt = tcnt - 4'h1;
        if (tcnt == 4'h0) begin
          next_word[DATA_W-1 -: SADC_BYTE_W] = pins.result_bus[SADC_BYTE_W-1:0];
          next_rd_n = 1'b1;
          next_bsel = 1'b0;
          next_tcnt = 4'(SADC_GUARD_PRE_CYC);
          next_state = SADC_H_PUSH;
        end
      end
      SADC_H_PUSH: begin
        // keeps the next start strobe clear of the read that just ended
        next_tcnt = tcnt - 4'h1;
        if (tcnt == 4'h0) begin
          next_state = SADC_H_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= SADC_H_IDLE;
      tcnt <= 4'h0;
      div <= 2'h0;
      ck <= 1'b0;
      strobe_n <= 1'b1;
      rd_n <= 1'b1;
      bsel <= 1'b0;
      word <= SADC_CODE_ZERO;
      seen_busy <= 1'b0;
    end else begin
      state <= next_state;
      tcnt <= next_tcnt;
      div <= next_div;
      ck <= next_ck;
      strobe_n <= next_strobe_n;
      rd_n <= next_rd_n;
      bsel <= next_bsel;
      word <= next_word;
      seen_busy <= next_seen_busy;
    end
  end
  // reads happen only after busy falls, far from any start edge
  assign pins.conv_clk_en = ck;
  assign pins.start_strobe_n = strobe_n;
  assign pins.cs_n = 1'b0;
  assign pins.rd_n = rd_n;
  assign pins.byte_sel = bsel;
  assign start_ack = (state == SADC_H_IDLE) && start_req && fifo_ready;
  assign conv_active = (state != SADC_H_IDLE);
  sadc_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid((state == SADC_H_PUSH) && (tcnt == 4'h0)),
    .in_ready(fifo_ready),
    .in_data(word),
    .out_valid(res_valid),
    .out_ready(res_ready),
    .out_data(res_data)
  );
endmodule : sadc_host

//--- verilog/sadc_pkg.sv
// shared constants for the converter port and its host
package sadc_pkg;
  localparam int SADC_DATA_W = 16;
  localparam int SADC_BYTE_W = 8;
  localparam int SADC_CONV_EDGES = 16;
  localparam int SADC_CLK_NS = 20;
  localparam int SADC_START_LOW_NS = 20;
  localparam int SADC_START_LOW_CYC = (SADC_START_LOW_NS + SADC_CLK_NS - 1) / SADC_CLK_NS;
  localparam int SADC_GUARD_PRE_NS = 125;
  localparam int SADC_GUARD_PRE_CYC = (SADC_GUARD_PRE_NS + SADC_CLK_NS - 1) / SADC_CLK_NS;
  localparam int SADC_GUARD_POST_NS = 10;
  localparam int SADC_GUARD_POST_CYC = (SADC_GUARD_POST_NS + SADC_CLK_NS - 1) / SADC_CLK_NS;
  localparam int SADC_RD_LOW_NS = 50;
  localparam int SADC_RD_LOW_CYC = (SADC_RD_LOW_NS + SADC_CLK_NS - 1) / SADC_CLK_NS;
  localparam int SADC_CONV_DIV = 2;
  localparam logic [15:0] SADC_CODE_ZERO = 16'h0000;
  localparam logic [15:0] SADC_CODE_MID = 16'h8000;
  localparam logic [15:0] SADC_CODE_FULL = 16'hFFFF;
  localparam logic [4:0] SADC_CNT_LAST = 5'h10;
  localparam logic [4:0] SADC_CNT_ZERO = 5'h00;
  localparam logic [4:0] SADC_CNT_ONE = 5'h01;
endpackage : sadc_pkg

//--- verilog/sadc_if.sv
// pin bundle between converter port and host
`timescale 1ns/10ps
interface sadc_if;
  import sadc_pkg::*;
  logic conv_clk_en;
  logic start_strobe_n;
  logic cs_n;
  logic rd_n;
  logic byte_sel;
  logic busy;
  logic [SADC_DATA_W-1:0] result_bus_out;
  logic result_bus_oe_n;
  logic [SADC_DATA_W-1:0] result_bus;
  // a released bus reads as all ones, as if pulled up
  assign result_bus = result_bus_oe_n ? {SADC_DATA_W{1'b1}} : result_bus_out;
  modport dev (input conv_clk_en, input start_strobe_n, input cs_n, input rd_n, input byte_sel,
    output busy, output result_bus_out, output result_bus_oe_n);
  modport host (output conv_clk_en, output start_strobe_n, output cs_n, output rd_n, output byte_sel,
    input busy, input result_bus);
endinterface : sadc_if

//--- verilog/sadc_fifo.sv
// parameterised valid/ready fifo
`timescale 1ns/10ps
module sadc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule : sadc_fifo

//--- verilog/sadc_dev.sv
// converter control and parallel read port
//
// Overview of operation
// - host supplies conversion clock, may gate it
// - conversion clock stays within allowed frequency range
// - host pulses start low while chip select low
// - start falling edge freezes the sampled input
// - first clock rise is cycle one, sixteen total
// - busy rises on start, falls at end
// - start only counts with chip select low
// - bus driven only when select and read low
// - host avoids reads around start falling edge
// - result is straight binary code
// - byte select low gives whole word
// - byte select high moves upper byte low
// - narrow host reads low byte then high byte
// - byte select acts without clock on bus
`timescale 1ns/10ps
module sadc_dev
  import sadc_pkg::*;
#(
  parameter int DATA_W = SADC_DATA_W
) (
  input wire logic clk,
  input wire logic rst_n,
  sadc_if.dev pins,
  input wire logic [DATA_W-1:0] sample_code
);
  typedef enum logic [1:0] {SADC_IDLE, SADC_HOLD, SADC_CONV} sadc_state_t;
  sadc_state_t state, next_state;
  logic [2:0] start_sync, cs_sync, ck_sync, next_start_sync, next_cs_sync, next_ck_sync;
  logic start_prev, ck_prev, next_start_prev, next_ck_prev;
  logic [4:0] edge_cnt, next_edge_cnt;
  logic [DATA_W-1:0] held_sample, next_held_sample, result, next_result;
  logic busy, next_busy;
  logic start_fall, ck_rise, start_low, cs_low, ck_high;
  logic [DATA_W-1:0] bus_word;
  // pins reach us from another domain: a change counts once stages two and three agree
  always_comb begin
    next_start_sync = {start_sync[1:0], pins.start_strobe_n};
    next_cs_sync = {cs_sync[1:0], pins.cs_n};
    next_ck_sync = {ck_sync[1:0], pins.conv_clk_en};
    next_start_prev = start_prev;
    next_ck_prev = ck_prev;
    if (start_sync[1] == start_sync[2]) begin
      next_start_prev = start_sync[2];
    end
    if (ck_sync[1] == ck_sync[2]) begin
      next_ck_prev = ck_sync[2];
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      start_sync <= 3'h7;
      cs_sync <= 3'h7;
      ck_sync <= 3'h0;
      // idle levels, so leaving reset never looks like an edge
      start_prev <= 1'b1;
      ck_prev <= 1'b0;
    end else begin
      start_sync <= next_start_sync;
      cs_sync <= next_cs_sync;
      ck_sync <= next_ck_sync;
      start_prev <= next_start_prev;
      ck_prev <= next_ck_prev;
    end
  end
  assign start_low = (start_sync[1] == start_sync[2]) && !start_sync[2];
  assign ck_high = (ck_sync[1] == ck_sync[2]) && ck_sync[2];
  assign cs_low = !cs_sync[1] && !cs_sync[2];
  assign start_fall = start_low && start_prev;
  assign ck_rise = ck_high && !ck_prev;
  always_comb begin
    next_state = state;
    next_edge_cnt = edge_cnt;
    next_held_sample = held_sample;
    next_result = result;
    next_busy = busy;
    unique case (state)
      SADC_IDLE: begin
        if (start_fall && cs_low) begin
          next_held_sample = sample_code;
          next_busy = 1'b1;
          next_edge_cnt = SADC_CNT_ZERO;
          next_state = SADC_HOLD;
          // a clock rise that settles together with the start edge is already cycle one
          if (ck_rise) begin
            next_edge_cnt = SADC_CNT_ONE;
            next_state = SADC_CONV;
          end
        end
      end
      SADC_HOLD: begin
        if (ck_rise) begin
          next_edge_cnt = SADC_CNT_ONE;
          next_state = SADC_CONV;
        end
      end
      SADC_CONV: begin
        if (ck_rise) begin
          next_edge_cnt = edge_cnt + 5'h01;
          if (edge_cnt + 5'h01 == SADC_CNT_LAST) begin
            next_result = held_sample;
            next_busy = 1'b0;
            next_state = SADC_IDLE;
          end
        end
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= SADC_IDLE;
      edge_cnt <= SADC_CNT_ZERO;
      held_sample <= SADC_CODE_ZERO;
      result <= SADC_CODE_ZERO;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      edge_cnt <= next_edge_cnt;
      held_sample <= next_held_sample;
      result <= next_result;
      busy <= next_busy;
    end
  end
  // bus steering is combinational so byte select acts without waiting for clk
  always_comb begin
    bus_word = result;
    if (pins.byte_sel) begin
      bus_word = {DATA_W{1'b0}};
      bus_word[SADC_BYTE_W-1:0] = result[DATA_W-1 -: SADC_BYTE_W];
    end
  end
  assign pins.busy = busy;
  assign pins.result_bus_out = bus_word;
  assign pins.result_bus_oe_n = pins.cs_n || pins.rd_n;
endmodule : sadc_dev

//--- tb/sadc_asserts.sv
// concurrent checks on the pin bundle between host and converter
`timescale 1ns/10ps
module sadc_asserts
  import sadc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic conv_clk_en,
  input wire logic start_strobe_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic byte_sel,
  input wire logic busy,
  input wire logic [SADC_DATA_W-1:0] result_bus_out,
  input wire logic result_bus_oe_n
);
  logic armed, next_armed, clk_q, busy_q, strobe_q, start_fall;
  logic [4:0] edge_cnt, next_edge_cnt;
  logic [15:0] word_q, next_word_q;
  assign start_fall = strobe_q && !start_strobe_n && !cs_n;
  // raw conversion clock rises are counted; the device sees them later through its sampler
  always_comb begin
    next_armed = armed;
    next_edge_cnt = edge_cnt;
    next_word_q = word_q;
    if (start_fall) begin
      next_armed = 1'b1;
      next_edge_cnt = 5'h00;
    end
    if ((armed || start_fall) && conv_clk_en && !clk_q) next_edge_cnt = next_edge_cnt + 5'h01;
    if (busy_q && !busy) begin
      next_armed = 1'b0;
      next_edge_cnt = 5'h00;
    end
    if (!result_bus_oe_n && !byte_sel) next_word_q = result_bus_out;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      armed <= 1'b0;
      edge_cnt <= 5'h00;
      word_q <= 16'h0000;
      clk_q <= 1'b0;
      busy_q <= 1'b0;
      strobe_q <= 1'b1;
    end else begin
      armed <= next_armed;
      edge_cnt <= next_edge_cnt;
      word_q <= next_word_q;
      clk_q <= conv_clk_en;
      busy_q <= busy;
      strobe_q <= start_strobe_n;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_bus_drive_gate: assert property (result_bus_oe_n == (cs_n || rd_n))
    else $error("bus enable does not follow select and read");
  chk_busy_rise_start: assert property (start_fall && !busy |-> ##[1:5] busy)
    else $error("busy did not rise after start");
  chk_busy_has_cause: assert property ($rose(busy) |-> armed)
    else $error("busy rose without a start");
  chk_sixteen_edges: assert property ($fell(busy) |-> edge_cnt == 5'h10)
    else $error("busy fell after wrong edge count");
  chk_busy_stays_high: assert property (busy && edge_cnt < 5'h10 |=> busy)
    else $error("busy dropped early");
  chk_upper_lane_zero: assert property (!result_bus_oe_n && byte_sel |-> result_bus_out[15:8] == 8'h00)
    else $error("upper lane not cleared in byte mode");
  chk_high_byte_lane: assert property ($rose(byte_sel) && !result_bus_oe_n && !$past(result_bus_oe_n)
    |-> result_bus_out[7:0] == word_q[15:8])
    else $error("high byte not on low lane");
  chk_result_held: assert property (!$fell(busy) && !result_bus_oe_n && !$past(result_bus_oe_n)
    && $stable(byte_sel) |-> $stable(result_bus_out))
    else $error("result changed without completion");
  cov_start: cover property (start_fall);
  cov_done: cover property ($fell(busy));
  cov_byte_read: cover property ($rose(byte_sel) && !result_bus_oe_n);
endmodule : sadc_asserts

//--- tb/testbench.sv
// bench: host and converter pair with a fifo, plus a converter driven directly
`timescale 1ns/10ps
module testbench;
  import sadc_pkg::*;
  localparam logic [15:0] CODES [3] = '{SADC_CODE_ZERO, SADC_CODE_MID, SADC_CODE_FULL};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic start_req = 1'b0;
  logic res_ready = 1'b0;
  logic drain = 1'b0;
  logic [15:0] code_a = 16'h0000;
  logic [15:0] code_b = 16'h0000;
  logic start_ack, conv_active, res_valid;
  logic [15:0] res_data;
  logic take;
  logic [15:0] exp_q[$];
  int seed = 8;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  int n_ack;
  sadc_if bus_a();
  sadc_if bus_b();
  sadc_dev i_sadc_dev (.clk(clk), .rst_n(rst_n), .pins(bus_a.dev), .sample_code(code_a));
  sadc_dev i_sadc_dev_b (.clk(clk), .rst_n(rst_n), .pins(bus_b.dev), .sample_code(code_b));
  sadc_host #(.BYTE_MODE(1'b1)) i_sadc_host (.clk(clk), .rst_n(rst_n), .pins(bus_a.host), .start_req(start_req),
    .start_ack(start_ack), .conv_active(conv_active), .res_valid(res_valid), .res_ready(res_ready),
    .res_data(res_data));
  sadc_asserts i_sadc_asserts (.clk(clk), .rst_n(rst_n), .conv_clk_en(bus_a.conv_clk_en),
    .start_strobe_n(bus_a.start_strobe_n), .cs_n(bus_a.cs_n), .rd_n(bus_a.rd_n), .byte_sel(bus_a.byte_sel),
    .busy(bus_a.busy), .result_bus_out(bus_a.result_bus_out), .result_bus_oe_n(bus_a.result_bus_oe_n));
  always #10 clk = ~clk;
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  // stall the fifo reader at random while draining; a word offered here is taken at the next rising edge
  always @(negedge clk) begin
    take = drain && ($random(seed) % 2 != 0);
    res_ready <= take;
    if (rst_n && take && res_valid === 1'b1) begin
      if (exp_q.size() == 0)
        check(16'(exp_q.size()), 16'h0001);
      else
        check(res_data, exp_q.pop_front());
    end
  end
  task automatic convert(input logic [15:0] code, input logic sel_n, input logic want);
    code_b = code;
    bus_b.cs_n = sel_n;
    repeat (SADC_GUARD_PRE_CYC) @(negedge clk);
    bus_b.start_strobe_n = 1'b0;
    repeat (5) @(negedge clk);
    bus_b.start_strobe_n = 1'b1;
    // the input must already be frozen, so a change now must not reach the result
    code_b = ~code;
    check(bus_b.busy, want);
    for (int i = 1; i <= 16; i++) begin
      bus_b.conv_clk_en = 1'b1;
      repeat (3) @(negedge clk);
      bus_b.conv_clk_en = 1'b0;
      repeat (3) @(negedge clk);
      if (i == 15) check(bus_b.busy, want);
    end
    repeat (6) @(negedge clk);
    check(bus_b.busy, 1'b0);
  endtask : convert
  task automatic read_b(input logic [15:0] want);
    bus_b.cs_n = 1'b0;
    @(negedge clk);
    check(16'(bus_b.result_bus_oe_n), 16'h0001);
    bus_b.rd_n = 1'b0;
    @(negedge clk);
    check(bus_b.result_bus, want);
    bus_b.byte_sel = 1'b1;
    #1;
    check(bus_b.result_bus, {8'h00, want[15:8]});
    bus_b.cs_n = 1'b1;
    #1;
    check(16'(bus_b.result_bus_oe_n), 16'h0001);
    @(negedge clk);
    bus_b.rd_n = 1'b1;
    bus_b.byte_sel = 1'b0;
  endtask : read_b
  task automatic wait_ack();
    // looks between edges, once the request has settled; the start is taken at the next rising edge
    n_ack = 0;
    #1;
    while (start_ack !== 1'b1 && n_ack < 400) begin
      @(negedge clk);
      #1;
      n_ack++;
    end
  endtask : wait_ack
  initial begin
    bus_b.conv_clk_en = 1'b0;
    bus_b.start_strobe_n = 1'b1;
    bus_b.cs_n = 1'b1;
    bus_b.rd_n = 1'b1;
    bus_b.byte_sel = 1'b0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    foreach (CODES[i]) begin
      convert(CODES[i], 1'b0, 1'b1);
      read_b(CODES[i]);
    end
    convert(16'h1234, 1'b1, 1'b0);
    read_b(SADC_CODE_FULL);
    // eight results fill the fifo, the ninth start must be refused until it drains
    for (int k = 0; k < 12; k++) begin
      code_a = 16'($random(seed));
      start_req = 1'b1;
      wait_ack();
      if (k == 8) begin
        check(16'(n_ack), 16'h0190);
        drain = 1'b1;
        wait_ack();
      end
      exp_q.push_back(code_a);
      @(negedge clk);
      start_req = 1'b0;
      n_ack = 0;
      do begin
        @(negedge clk);
        n_ack++;
      end while (conv_active === 1'b1 && n_ack < 400);
      check(16'(conv_active), 16'h0000);
    end
    n_ack = 0;
    while (exp_q.size() != 0 && n_ack < 400) begin
      @(negedge clk);
      n_ack++;
    end
    repeat (4) @(negedge clk);
    check(16'(exp_q.size()), 16'h0000);
    check(res_valid, 1'b0);
    end_of_test();
  end
endmodule : testbench
